//--- otpc_host.sv
// host side model: configuration fields, read margin and boost supply state
`timescale 1ns/100ps
`default_nettype none
module otpc_host (
  input  wire logic           clk_i,
  output otpc_pkg::otpc_cfg_t cfg_o,
  output otpc_pkg::otpc_bias_t bias_o,
  output logic                uv_o
);
  initial begin
    cfg_o = '0;
    bias_o = '0;
    uv_o = 1'b0;
  end
  // all fields written before any program code
  task automatic set(input logic [38:0] c, input logic [1:0] b, input logic u);
    @(posedge clk_i);
    cfg_o <= c;
    bias_o <= b;
    uv_o <= u;
  endtask
endmodule
`default_nettype wire

//--- otpc_params.svh
// timing, offsets, field positions and reset values of the one-time store access block
`ifndef OTPC_PARAMS_SVH
`define OTPC_PARAMS_SVH

// ************************************************************
// register offsets and values
// ************************************************************
`define OTPC_ADDR_W            5
`define OTPC_OFS_READBACK      5'h1e
`define OTPC_OFS_REVISION      5'h1f
`define OTPC_READBACK_RST      10'h000
// revision code, value arbitrary
`define OTPC_REVISION_CODE     9'h0c1
`define OTPC_WORD_W            10

// ************************************************************
// store layout
// ************************************************************
`define OTPC_STORE_BITS        40
`define OTPC_LOCK_BIT          39
`define OTPC_STORE_RST         40'h00_0000_0000

// ************************************************************
// operation codes
// ************************************************************
`define OTPC_OP_NOP0           2'h0
`define OTPC_OP_REFRESH        2'h1
`define OTPC_OP_PROGRAM        2'h2
`define OTPC_OP_NOP3           2'h3

// ************************************************************
// timing
// ************************************************************
`define OTPC_CLK_MHZ           100
`define OTPC_REFRESH_NS        1000
`define OTPC_PROGRAM_US        100
`define OTPC_REFRESH_CYC       ((`OTPC_REFRESH_NS * `OTPC_CLK_MHZ) / 1000)
`define OTPC_PROGRAM_CYC       (`OTPC_PROGRAM_US * `OTPC_CLK_MHZ)
`define OTPC_CNT_W             16

`endif

//--- otpc_pkg.sv
// types of the one-time store access block
`default_nettype none
package otpc_pkg;

  // configuration image, store bits 38:0 less the lock bit, msb first
  typedef struct packed {
    logic [1:0] overcurrent_compare_level;
    logic       ch2_thermal_auto_recovery;
    logic       ch1_thermal_auto_recovery;
    logic [2:0] fail_safe_mode_select;
    logic       ch2_enable;
    logic       ch1_enable;
    logic [4:0] ch2_off_time;
    logic [4:0] ch1_off_time;
    logic [1:0] ch2_sense_range;
    logic [7:0] ch2_voltage_threshold;
    logic [1:0] ch1_sense_range;
    logic [7:0] ch1_voltage_threshold;
  } otpc_cfg_t;

  typedef struct packed {
    logic       bias_high;
    logic       bias_low;
  } otpc_bias_t;

  typedef enum logic [1:0] {
    OTPC_ST_IDLE    = 2'b00,
    OTPC_ST_REFRESH = 2'b01,
    OTPC_ST_PROGRAM = 2'b10
  } otpc_state_t;

endpackage

`default_nettype wire

//--- otpc_store.sv
// one-time configuration store: refresh, program, read-back and revision
`timescale 1ns/100ps
`include "otpc_params.svh"
`default_nettype none

module otpc_store #(
  parameter int unsigned PROGRAM_CYCLES = `OTPC_PROGRAM_CYC
) (
  input  wire logic                     clk_i,
  input  wire logic                     resetn_i,
  input  wire logic                     reg_rd_i,
  input  wire logic [`OTPC_ADDR_W-1:0]  reg_addr_i,
  output logic      [`OTPC_WORD_W-1:0]  reg_rdata_o,
  input  wire logic                     op_wr_i,
  input  wire logic [1:0]               op_code_i,
  input  wire logic [1:0]               word_sel_i,
  input  wire otpc_pkg::otpc_bias_t     bias_i,
  input  wire otpc_pkg::otpc_cfg_t      cfg_i,
  input  wire logic                     boost_supply_rail_uv_i,
  input  wire logic                     status_rd_i,
  output otpc_pkg::otpc_cfg_t           cfg_o,
  output otpc_pkg::otpc_bias_t          read_bias_o,
  output logic                          busy_o,
  output logic                          prog_fail_o,
  output logic                          lock_o
);

  // ************************************************************
  // timing counts
  // ************************************************************
  localparam logic [`OTPC_CNT_W-1:0] REFRESH_LAST =
    `OTPC_CNT_W'(((`OTPC_REFRESH_CYC < 1) ? 1 : `OTPC_REFRESH_CYC) - 1);
  localparam logic [`OTPC_CNT_W-1:0] PROGRAM_LAST =
    `OTPC_CNT_W'(((PROGRAM_CYCLES < 1) ? 1 : PROGRAM_CYCLES) - 1);

  // ************************************************************
  // state
  // ************************************************************
  otpc_pkg::otpc_state_t             state_ff;
  otpc_pkg::otpc_state_t             nxt_state;
  logic [`OTPC_CNT_W-1:0]            cnt_ff;
  logic [`OTPC_STORE_BITS-1:0]       store_ff;
  logic [`OTPC_WORD_W-1:0]           readback_ff;
  logic [`OTPC_WORD_W-1:0]           rdata_ff;
  otpc_pkg::otpc_cfg_t               cfg_ff;
  otpc_pkg::otpc_bias_t              bias_ff;
  logic                              busy_ff;
  logic                              fail_ff;

  // ************************************************************
  // decode
  // ************************************************************
  wire logic                         idle      = (state_ff == otpc_pkg::OTPC_ST_IDLE);
  wire logic                         locked    = store_ff[`OTPC_LOCK_BIT];
  wire logic                         cnt_done  = (state_ff == otpc_pkg::OTPC_ST_REFRESH) ?
                                                 (cnt_ff == REFRESH_LAST) :
                                                 (cnt_ff == PROGRAM_LAST);
  wire logic                         op_take   = op_wr_i & idle;
  wire logic                         go_ref    = op_take & (op_code_i == `OTPC_OP_REFRESH);
  wire logic                         go_prog   = op_take & (op_code_i == `OTPC_OP_PROGRAM) &
                                                 ~locked;
  wire logic                         ref_end   = (state_ff == otpc_pkg::OTPC_ST_REFRESH) &
                                                 cnt_done;
  wire logic                         prog_end  = (state_ff == otpc_pkg::OTPC_ST_PROGRAM) &
                                                 cnt_done;
  wire logic                         uv_hit    = (state_ff == otpc_pkg::OTPC_ST_PROGRAM) &
                                                 boost_supply_rail_uv_i;
  // program image: lock bit set with the configuration fields
  wire logic [`OTPC_STORE_BITS-1:0]  prog_img  = {1'b1, cfg_i};
  wire logic                         nxt_busy  = (nxt_state != otpc_pkg::OTPC_ST_IDLE);
  // counter restarts at every take and at every end
  wire logic [`OTPC_CNT_W-1:0]       nxt_cnt   = (idle | cnt_done) ? '0 : cnt_ff + 1'b1;
  wire otpc_pkg::otpc_bias_t         nxt_bias  = go_ref  ? bias_i :
                                                 ref_end ? otpc_pkg::otpc_bias_t'(2'b00) :
                                                 bias_ff;
  // a fresh undervoltage wins over a clearing status read
  wire logic                         nxt_fail  = uv_hit | (fail_ff & ~status_rd_i);

  // ************************************************************
  // read-back word selection
  // ************************************************************
  logic [`OTPC_WORD_W-1:0]           store_word [4];
  for (genvar gw = 0; gw < 4; gw++) begin : g_word
    assign store_word[gw] = store_ff[gw*`OTPC_WORD_W +: `OTPC_WORD_W];
  end
  wire logic [`OTPC_WORD_W-1:0]      sel_word  = store_word[word_sel_i];

  // ************************************************************
  // register read decode
  // ************************************************************
  // unmapped offsets read zero
  wire logic                         hit_rdbk  = (reg_addr_i == `OTPC_OFS_READBACK);
  wire logic                         hit_rev   = (reg_addr_i == `OTPC_OFS_REVISION);
  wire logic [`OTPC_WORD_W-1:0]      rev_word  = {1'b0, `OTPC_REVISION_CODE};
  wire logic [`OTPC_WORD_W-1:0]      nxt_rdata = hit_rdbk ? readback_ff :
                                                 hit_rev  ? rev_word : `OTPC_WORD_W'(0);

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    case (state_ff)
      otpc_pkg::OTPC_ST_IDLE: begin
        if (go_ref) begin
          nxt_state = otpc_pkg::OTPC_ST_REFRESH;
        end else if (go_prog) begin
          nxt_state = otpc_pkg::OTPC_ST_PROGRAM;
        end else begin
          nxt_state = otpc_pkg::OTPC_ST_IDLE;
        end
      end
      otpc_pkg::OTPC_ST_REFRESH,
      otpc_pkg::OTPC_ST_PROGRAM: begin
        nxt_state = cnt_done ? otpc_pkg::OTPC_ST_IDLE : state_ff;
      end
      default: begin
        nxt_state = otpc_pkg::OTPC_ST_IDLE;
      end
    endcase
  end

  // ************************************************************
  // sequencer; power-up refresh loads the configuration
  // ************************************************************
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_ff <= otpc_pkg::OTPC_ST_REFRESH;
      cnt_ff   <= '0;
      busy_ff  <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      busy_ff  <= nxt_busy;
    end
  end

  // ************************************************************
  // read margin, applied only while a refresh runs
  // ************************************************************
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bias_ff <= '0;
    end else begin
      bias_ff <= nxt_bias;
    end
  end

  // ************************************************************
  // store; only a completed program sets bits
  // ************************************************************
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      store_ff <= `OTPC_STORE_RST;
    end else if (prog_end) begin
      store_ff <= prog_img;
    end
  end

  // ************************************************************
  // read-back word and configuration image, loaded at refresh end
  // ************************************************************
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      readback_ff <= `OTPC_READBACK_RST;
      cfg_ff      <= '0;
    end else if (ref_end) begin
      readback_ff <= sel_word;
      cfg_ff      <= store_ff[`OTPC_LOCK_BIT-1:0];
    end
  end

  // ************************************************************
  // register read port
  // ************************************************************
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_ff <= '0;
    end else if (reg_rd_i) begin
      rdata_ff <= nxt_rdata;
    end
  end

  // ************************************************************
  // program fail flag, cleared by a status read
  // ************************************************************
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fail_ff <= 1'b0;
    end else begin
      fail_ff <= nxt_fail;
    end
  end

  assign reg_rdata_o = rdata_ff;
  assign cfg_o       = cfg_ff;
  assign read_bias_o = bias_ff;
  assign busy_o      = busy_ff;
  assign prog_fail_o = fail_ff;
  assign lock_o      = store_ff[`OTPC_LOCK_BIT];

endmodule

`default_nettype wire

//--- otpc_store_properties.sv
// concurrent checks on the ports of the one-time store access block
`timescale 1ns/100ps
`include "otpc_params.svh"
`default_nettype none
module otpc_store_chk #(
  parameter int unsigned PROGRAM_CYCLES = 20
) (
  input wire logic                 clk_i,
  input wire logic                 resetn_i,
  input wire logic                 reg_rd_i,
  input wire logic [4:0]           reg_addr_i,
  input wire logic [9:0]           reg_rdata_o,
  input wire logic                 op_wr_i,
  input wire logic [1:0]           op_code_i,
  input wire logic [1:0]           word_sel_i,
  input wire otpc_pkg::otpc_bias_t bias_i,
  input wire otpc_pkg::otpc_cfg_t  cfg_i,
  input wire logic                 boost_supply_rail_uv_i,
  input wire logic                 status_rd_i,
  input wire otpc_pkg::otpc_cfg_t  cfg_o,
  input wire otpc_pkg::otpc_bias_t read_bias_o,
  input wire logic                 busy_o,
  input wire logic                 prog_fail_o,
  input wire logic                 lock_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  wire take_w = op_wr_i && !busy_o;
  // length of a program run, counted in busy cycles
  logic        prog_run;
  logic [15:0] prog_len;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prog_run <= 1'b0;
      prog_len <= 16'h0000;
    end else if (take_w && op_code_i == 2'h2 && !lock_o) begin
      prog_run <= 1'b1;
      prog_len <= 16'h0000;
    end else if (prog_run && busy_o) begin
      prog_len <= prog_len + 16'h0001;
    end else begin
      prog_run <= 1'b0;
    end
  end
  a_program_span: assert property (prog_run && !busy_o |->
    prog_len == 16'(PROGRAM_CYCLES) && lock_o) else $error("program length wrong");
  a_revision_read: assert property (reg_rd_i && reg_addr_i == 5'h1f |=>
    reg_rdata_o == {1'b0, `OTPC_REVISION_CODE}) else $error("revision read wrong");
  a_unmapped_zero: assert property (reg_rd_i && reg_addr_i < 5'h1e |=>
    reg_rdata_o == 10'h000) else $error("unmapped read not zero");
  a_refresh_span: assert property (take_w && op_code_i == 2'h1 |=>
    busy_o [*8] ##91 busy_o ##[1:2] !busy_o) else $error("refresh length wrong");
  a_bias_applied: assert property (take_w && op_code_i == 2'h1 |=>
    read_bias_o == $past(bias_i)) else $error("read margin not applied");
  a_nop_quiet: assert property (take_w && op_code_i[0] == op_code_i[1] |=>
    !busy_o && $stable(lock_o)) else $error("nop started an operation");
  a_locked_refuse: assert property (take_w && op_code_i == 2'h2 && lock_o |=>
    !busy_o) else $error("program ran on locked store");
  a_lock_stays: assert property (lock_o |=> lock_o) else $error("lock bit dropped");
  a_fail_cause: assert property ($rose(prog_fail_o) |->
    $past(boost_supply_rail_uv_i)) else $error("fail flag without undervoltage");
  a_fail_clear: assert property (status_rd_i && !boost_supply_rail_uv_i |=>
    !prog_fail_o) else $error("fail flag not cleared");
  a_cfg_hold: assert property (!busy_o && !op_wr_i |=> $stable(cfg_o))
    else $error("configuration changed while idle");
  c_refresh: cover property (take_w && op_code_i == 2'h1);
  c_program: cover property (take_w && op_code_i == 2'h2 && !lock_o);
  c_fail: cover property ($rose(prog_fail_o));
endmodule
bind otpc_store otpc_store_chk #(.PROGRAM_CYCLES(PROGRAM_CYCLES)) u_otpc_store_chk (
  .clk_i(clk_i), .resetn_i(resetn_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
  .reg_rdata_o(reg_rdata_o), .op_wr_i(op_wr_i), .op_code_i(op_code_i),
  .word_sel_i(word_sel_i), .bias_i(bias_i), .cfg_i(cfg_i), .status_rd_i(status_rd_i),
  .boost_supply_rail_uv_i(boost_supply_rail_uv_i), .cfg_o(cfg_o), .busy_o(busy_o),
  .read_bias_o(read_bias_o), .prog_fail_o(prog_fail_o), .lock_o(lock_o));
`default_nettype wire

//--- tb_top.sv
// self-checking bench of the one-time store access block
`timescale 1ns/100ps
`include "otpc_params.svh"
`default_nettype none
module tb_top;
  localparam logic [38:0] CFG_A = 39'h5_ac3f_09e17;
  localparam logic [39:0] IMG_A = {1'b1, CFG_A};
  logic clk_i, resetn_i, reg_rd_i, op_wr_i, status_rd_i, busy_o, prog_fail_o, lock_o, uv;
  logic [4:0] reg_addr_i;
  logic [9:0] reg_rdata_o, d;
  logic [1:0] op_code_i, word_sel_i;
  otpc_pkg::otpc_bias_t bias, read_bias;
  otpc_pkg::otpc_cfg_t  cfg, cfg_o;
  int n_errors = 0;
  int n_tests = 0;
  otpc_store #(.PROGRAM_CYCLES(20)) u_otpc_store (.clk_i(clk_i), .resetn_i(resetn_i),
    .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_rdata_o(reg_rdata_o),
    .op_wr_i(op_wr_i), .op_code_i(op_code_i), .word_sel_i(word_sel_i), .bias_i(bias),
    .cfg_i(cfg), .boost_supply_rail_uv_i(uv), .status_rd_i(status_rd_i), .cfg_o(cfg_o),
    .read_bias_o(read_bias), .busy_o(busy_o), .prog_fail_o(prog_fail_o), .lock_o(lock_o));
  otpc_host u_otpc_host (.clk_i(clk_i), .cfg_o(cfg), .bias_o(bias), .uv_o(uv));
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string name, input logic [39:0] seen, input logic [39:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 2000; i++) begin
      @(posedge clk_i);
      #1;
      if (busy_o === 1'b0) return;
    end
    n_errors++;
    complete_run();
  endtask
  task automatic op(input logic [1:0] c, input bit w);
    @(posedge clk_i);
    op_wr_i <= 1'b1;
    op_code_i <= c;
    @(posedge clk_i);
    op_wr_i <= 1'b0;
    if (w) wait_idle();
  endtask
  task automatic rd(input logic [4:0] a, output logic [9:0] v);
    @(posedge clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 v = reg_rdata_o;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    {resetn_i, reg_rd_i, op_wr_i, status_rd_i} = '0;
    {reg_addr_i, op_code_i, word_sel_i} = '0;
    repeat (10) @(posedge clk_i);
    resetn_i <= 1'b1;
    wait_idle();
    chk("cfg after power-up", cfg_o, 40'h0);
    rd(5'h1e, d);
    chk("readback reset", d, `OTPC_READBACK_RST);
    rd(5'h1f, d);
    chk("revision", d, {1'b0, `OTPC_REVISION_CODE});
    rd(5'h05, d);
    chk("unmapped", d, 10'h000);
    $display("test reset and registers done");
    u_otpc_host.set(CFG_A, 2'b00, 1'b1);
    op(2'h1, 0);
    op(2'h2, 1);
    chk("lock after busy program", lock_o, 1'b0);
    chk("fail untouched", prog_fail_o, 1'b0);
    op(2'h2, 1);
    chk("lock after program", lock_o, 1'b1);
    chk("fail flag", prog_fail_o, 1'b1);
    u_otpc_host.set(CFG_A, 2'b00, 1'b0);
    @(posedge clk_i) status_rd_i <= 1'b1;
    @(posedge clk_i) status_rd_i <= 1'b0;
    #1 chk("fail after read", prog_fail_o, 1'b0);
    $display("test program done");
    for (int b = 1; b < 3; b++) begin
      u_otpc_host.set(CFG_A, b[1:0], 1'b0);
      for (int w = 0; w < 4; w++) begin
        @(posedge clk_i) word_sel_i <= w[1:0];
        op(2'h1, 1);
        rd(5'h1e, d);
        chk("readback word", d, {30'h0, IMG_A[w*10 +: 10]});
        chk("cfg image", cfg_o, CFG_A);
      end
    end
    $display("test verify done");
    u_otpc_host.set(~CFG_A, 2'b00, 1'b0);
    op(2'h2, 1);
    op(2'h1, 1);
    chk("locked store", cfg_o, CFG_A);
    @(posedge clk_i) word_sel_i <= 2'h0;
    op(2'h0, 1);
    op(2'h3, 1);
    rd(5'h1e, d);
    chk("readback after nop", d, IMG_A[39:30]);
    $display("test locked and nop done");
    complete_run();
  end
endmodule
`default_nettype wire
